// [rtl/mbcfg_pkg.sv]
package mbcfg_pkg;
  // ==========================================================
  // clock and timing
  localparam int CLK_HZ = 125_000_000;
  localparam int CYC_PER_MS = CLK_HZ / 1000;
  localparam int TIMEOUT_STEP_MS = 100;
  localparam int TIMEOUT_STEP_CYCLES = CYC_PER_MS * TIMEOUT_STEP_MS;
  localparam logic [6:0] TIMEOUT_MAX = 7'h64;
  // ==========================================================
  // register byte addresses
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_TIMEOUT = 8'h04;
  localparam logic [7:0] REG_WAIT = 8'h08;
  localparam logic [7:0] REG_ACTIVE = 8'h0C;
  localparam logic [7:0] REG_IRQ_STATUS = 8'h10;
  localparam logic [7:0] REG_IRQ_MASK = 8'h14;
  localparam logic [7:0] REG_VOLT = 8'h18;
  // ==========================================================
  // control register fields and reset values
  localparam int CTRL_STOP_LSB = 0;
  localparam int CTRL_DETECT_BIT = 2;
  localparam int CTRL_RTS_BIT = 3;
  localparam int CTRL_UNIT_BIT = 4;
  localparam logic [1:0] STOP_RAMP = 2'h0;
  localparam logic [1:0] STOP_FAST = 2'h1;
  localparam logic [1:0] STOP_COAST = 2'h2;
  localparam logic [1:0] STOP_ALARM = 2'h3;
  localparam logic [4:0] CTRL_RESET = 5'h0F;
  localparam logic [6:0] TIMEOUT_RESET = 7'h14;
  localparam logic [7:0] WAIT_RESET = 8'h05;
  // ==========================================================
  // power-up settings
  localparam logic [7:0] ADDR_DEFAULT = 8'h1F;
  localparam logic [7:0] ADDR_SILENT = 8'h00;
  localparam logic [3:0] BAUD_DEFAULT = 4'h3;
  localparam logic [3:0] BAUD_MAX = 4'h8;
  localparam logic [1:0] PAR_NONE = 2'h0;
  localparam logic [1:0] PAR_EVEN = 2'h1;
  localparam logic [1:0] PAR_ODD = 2'h2;
  // ==========================================================
  // interrupt bits and monitor scaling
  localparam int IRQ_FAULT = 0;
  localparam int IRQ_REPLY = 1;
  localparam logic [15:0] VOLT_DIV = 16'h000A;
  // ==========================================================
  typedef enum logic [1:0] {
    MBCFG_IDLE = 2'b00,
    MBCFG_WAIT = 2'b01,
    MBCFG_SEND = 2'b11
  } mbcfg_state_e;

  // clock cycles per bit for a baud code
  function automatic logic [19:0] mbcfg_bit_cycles(input logic [3:0] code);
    int baud;
    case (code)
      4'h0: baud = 1200;
      4'h1: baud = 2400;
      4'h2: baud = 4800;
      4'h3: baud = 9600;
      4'h4: baud = 19200;
      4'h5: baud = 38400;
      4'h6: baud = 57600;
      4'h7: baud = 76800;
      default: baud = 115200;
    endcase
    return 20'(CLK_HZ / baud);
  endfunction : mbcfg_bit_cycles
endpackage : mbcfg_pkg

// [rtl/mbcfg_top.sv]
`timescale 1ns/1ps
module mbcfg_top
  import mbcfg_pkg::*;
#(
  parameter int TICK_CYCLES = TIMEOUT_STEP_CYCLES,
  parameter int MS_CYCLES = CYC_PER_MS
) (
  // clock and reset
  input wire logic sys_clk,
  input wire logic rst_b,
  // register port
  input wire logic [7:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata,
  // power-up settings from parameter storage
  input wire logic [7:0] station_address_setting,
  input wire logic [3:0] baud_code_setting,
  input wire logic [1:0] parity_select_setting,
  // link events from the protocol engine
  input wire logic rx_byte_valid,
  input wire logic rx_request_done,
  input wire logic [7:0] rx_request_address,
  input wire logic tx_done,
  // link control
  output logic addr_match,
  output logic tx_start,
  output logic rts,
  output logic [19:0] bit_period_cycles,
  output logic parity_enable,
  output logic parity_odd,
  // fault and stop actions
  output logic comm_fault,
  output logic stop_ramp,
  output logic stop_fast,
  output logic stop_coast,
  output logic fault_alarm,
  output logic irq,
  // output voltage monitor, raw in 0.1 V
  input wire logic [15:0] volt_monitor_raw,
  output logic [15:0] volt_monitor_reg
);

  // ==========================================================
  // software registers
  logic [4:0] ctrl;
  logic [6:0] comm_loss_timeout;
  logic [7:0] reply_wait_time;
  logic [1:0] irq_status;
  logic [1:0] irq_mask;
  logic [4:0] next_ctrl;
  logic [6:0] next_comm_loss_timeout;
  logic [7:0] next_reply_wait_time;
  logic [1:0] next_irq_status;
  logic [1:0] next_irq_mask;
  logic [1:0] events;
  logic [1:0] comm_fault_stop_action;
  logic comm_fault_detect_enable;
  logic rts_direction_control;
  logic voltage_monitor_unit_select;

  assign comm_fault_stop_action = ctrl[CTRL_STOP_LSB +: 2];
  assign comm_fault_detect_enable = ctrl[CTRL_DETECT_BIT];
  assign rts_direction_control = ctrl[CTRL_RTS_BIT];
  assign voltage_monitor_unit_select = ctrl[CTRL_UNIT_BIT];

  always_comb begin
    next_ctrl = ctrl;
    next_comm_loss_timeout = comm_loss_timeout;
    next_reply_wait_time = reply_wait_time;
    next_irq_mask = irq_mask;
    next_irq_status = irq_status;
    if (reg_wr) begin
      case (reg_addr)
        REG_CTRL: next_ctrl = reg_wdata[4:0];
        // values above 10.0 s are held at the top of the range
        REG_TIMEOUT: next_comm_loss_timeout = (reg_wdata[6:0] > TIMEOUT_MAX) ? TIMEOUT_MAX : reg_wdata[6:0];
        REG_WAIT: next_reply_wait_time = reg_wdata[7:0];
        REG_IRQ_MASK: next_irq_mask = reg_wdata[1:0];
        REG_IRQ_STATUS: next_irq_status = irq_status & ~reg_wdata[1:0];
        default: ;
      endcase
    end
    // a new event wins over a write-one clear in the same cycle
    next_irq_status = next_irq_status | events;
  end

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      ctrl <= CTRL_RESET;
      comm_loss_timeout <= TIMEOUT_RESET;
      reply_wait_time <= WAIT_RESET;
      irq_status <= 2'h0;
      irq_mask <= 2'h0;
    end else begin
      ctrl <= next_ctrl;
      comm_loss_timeout <= next_comm_loss_timeout;
      reply_wait_time <= next_reply_wait_time;
      irq_status <= next_irq_status;
      irq_mask <= next_irq_mask;
    end
  end

  assign irq = |(irq_status & irq_mask);

  // ==========================================================
  // settings caught once after reset release
  logic cfg_loaded;
  logic [7:0] active_address;
  logic [3:0] active_baud;
  logic [1:0] active_parity;
  logic next_cfg_loaded;
  logic [7:0] next_active_address;
  logic [3:0] next_active_baud;
  logic [1:0] next_active_parity;
  logic [19:0] next_bit_period_cycles;
  logic next_parity_enable;
  logic next_parity_odd;
  // reset value kept as a named constant so the reset branch loads constants only
  localparam logic [19:0] BIT_CYCLES_RESET = mbcfg_bit_cycles(BAUD_DEFAULT);

  always_comb begin
    next_cfg_loaded = 1'b1;
    next_active_address = active_address;
    next_active_baud = active_baud;
    next_active_parity = active_parity;
    // later changes of the inputs are ignored until the next reset
    if (!cfg_loaded) begin
      next_active_address = station_address_setting;
      // codes past the table fall back to the default speed
      next_active_baud = (baud_code_setting > BAUD_MAX) ? BAUD_DEFAULT : baud_code_setting;
      next_active_parity = (parity_select_setting > PAR_ODD) ? PAR_NONE : parity_select_setting;
    end
    next_bit_period_cycles = mbcfg_bit_cycles(next_active_baud);
    next_parity_enable = (next_active_parity != PAR_NONE);
    next_parity_odd = (next_active_parity == PAR_ODD);
  end

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      cfg_loaded <= 1'b0;
      active_address <= ADDR_DEFAULT;
      active_baud <= BAUD_DEFAULT;
      active_parity <= PAR_NONE;
      bit_period_cycles <= BIT_CYCLES_RESET;
      parity_enable <= 1'b0;
      parity_odd <= 1'b0;
    end else begin
      cfg_loaded <= next_cfg_loaded;
      active_address <= next_active_address;
      active_baud <= next_active_baud;
      active_parity <= next_active_parity;
      bit_period_cycles <= next_bit_period_cycles;
      parity_enable <= next_parity_enable;
      parity_odd <= next_parity_odd;
    end
  end

  // zero address never matches, so no reply can be started
  assign addr_match = (active_address != ADDR_SILENT) && (rx_request_address == active_address);

  // ==========================================================
  // communication loss supervision
  logic [23:0] tick_cnt;
  logic [6:0] tenths;
  logic [23:0] next_tick_cnt;
  logic [6:0] next_tenths;
  logic next_comm_fault;
  logic [3:0] next_stops;

  always_comb begin
    next_tick_cnt = tick_cnt;
    next_tenths = tenths;
    next_comm_fault = comm_fault;
    if (!comm_fault_detect_enable || rx_byte_valid) begin
      next_tick_cnt = 24'h000000;
      next_tenths = 7'h00;
      next_comm_fault = 1'b0;
    end else begin
      if (tick_cnt == 24'(TICK_CYCLES - 1)) begin
        next_tick_cnt = 24'h000000;
        if (tenths != TIMEOUT_MAX + 7'h01) begin
          next_tenths = tenths + 7'h01;
        end
      end else begin
        next_tick_cnt = tick_cnt + 24'h000001;
      end
      // strictly longer than the setting
      if (tenths > comm_loss_timeout) begin
        next_comm_fault = 1'b1;
      end
    end
    next_stops = 4'h0;
    if (next_comm_fault) begin
      next_stops[STOP_RAMP] = (comm_fault_stop_action == STOP_RAMP);
      next_stops[STOP_FAST] = (comm_fault_stop_action == STOP_FAST);
      next_stops[STOP_COAST] = (comm_fault_stop_action == STOP_COAST);
      next_stops[STOP_ALARM] = (comm_fault_stop_action == STOP_ALARM);
    end
  end

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      tick_cnt <= 24'h000000;
      tenths <= 7'h00;
      comm_fault <= 1'b0;
      stop_ramp <= 1'b0;
      stop_fast <= 1'b0;
      stop_coast <= 1'b0;
      fault_alarm <= 1'b0;
    end else begin
      tick_cnt <= next_tick_cnt;
      tenths <= next_tenths;
      comm_fault <= next_comm_fault;
      stop_ramp <= next_stops[STOP_RAMP];
      stop_fast <= next_stops[STOP_FAST];
      stop_coast <= next_stops[STOP_COAST];
      fault_alarm <= next_stops[STOP_ALARM];
    end
  end

  // ==========================================================
  // reply sequencing and direction control
  mbcfg_state_e state;
  mbcfg_state_e next_state;
  logic [16:0] ms_cnt;
  logic [7:0] wait_ms;
  logic [16:0] next_ms_cnt;
  logic [7:0] next_wait_ms;

  always_comb begin
    next_state = state;
    next_ms_cnt = ms_cnt;
    next_wait_ms = wait_ms;
    tx_start = 1'b0;
    case (state)
      MBCFG_IDLE: begin
        next_ms_cnt = 17'h00000;
        next_wait_ms = 8'h00;
        if (rx_request_done && addr_match) begin
          next_state = MBCFG_WAIT;
        end
      end
      MBCFG_WAIT: begin
        if (wait_ms == reply_wait_time) begin
          tx_start = 1'b1;
          next_state = MBCFG_SEND;
        end else if (ms_cnt == 17'(MS_CYCLES - 1)) begin
          next_ms_cnt = 17'h00000;
          next_wait_ms = wait_ms + 8'h01;
        end else begin
          next_ms_cnt = ms_cnt + 17'h00001;
        end
      end
      MBCFG_SEND: begin
        if (tx_done) begin
          next_state = MBCFG_IDLE;
        end
      end
      default: next_state = MBCFG_IDLE;
    endcase
  end

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      state <= MBCFG_IDLE;
      ms_cnt <= 17'h00000;
      wait_ms <= 8'h00;
    end else begin
      state <= next_state;
      ms_cnt <= next_ms_cnt;
      wait_ms <= next_wait_ms;
    end
  end

  // with direction control set, rts rises with the send state, the first cycle the engine drives the line; with it clear, rts stays high
  assign rts = !rts_direction_control || (state == MBCFG_SEND);
  assign events[IRQ_FAULT] = next_comm_fault && !comm_fault;
  assign events[IRQ_REPLY] = (state == MBCFG_SEND) && tx_done;

  // ==========================================================
  // voltage monitor and read data
  logic [15:0] next_volt_monitor_reg;
  logic [31:0] next_reg_rdata;

  always_comb begin
    // the divide is paid once per cycle; the monitor is slow anyway
    next_volt_monitor_reg = voltage_monitor_unit_select ? (volt_monitor_raw / VOLT_DIV) : volt_monitor_raw;
    next_reg_rdata = 32'h00000000;
    if (reg_rd) begin
      case (reg_addr)
        REG_CTRL: next_reg_rdata = {27'h0000000, ctrl};
        REG_TIMEOUT: next_reg_rdata = {25'h0000000, comm_loss_timeout};
        REG_WAIT: next_reg_rdata = {24'h000000, reply_wait_time};
        REG_ACTIVE: next_reg_rdata = {13'h0000, state, comm_fault, 2'h0, active_parity, active_baud, active_address};
        REG_IRQ_STATUS: next_reg_rdata = {30'h00000000, irq_status};
        REG_IRQ_MASK: next_reg_rdata = {30'h00000000, irq_mask};
        REG_VOLT: next_reg_rdata = {16'h0000, volt_monitor_reg};
        default: next_reg_rdata = 32'h00000000;
      endcase
    end
  end

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      volt_monitor_reg <= 16'h0000;
      reg_rdata <= 32'h00000000;
    end else begin
      volt_monitor_reg <= next_volt_monitor_reg;
      reg_rdata <= next_reg_rdata;
    end
  end

endmodule : mbcfg_top

// [testbench/mbcfg_props.sv]
`timescale 1ns/1ps
module mbcfg_props
  import mbcfg_pkg::*;
#(
  parameter int TICK_CYCLES = TIMEOUT_STEP_CYCLES
) (
  // clock and reset
  input wire logic sys_clk,
  input wire logic rst_b,
  // link side
  input wire logic rx_byte_valid,
  input wire logic [7:0] rx_request_address,
  input wire logic addr_match,
  input wire logic tx_start,
  input wire logic rts,
  input wire logic [19:0] bit_period_cycles,
  input wire logic parity_enable,
  input wire logic parity_odd,
  // fault outputs
  input wire logic comm_fault,
  input wire logic stop_ramp,
  input wire logic stop_fast,
  input wire logic stop_coast,
  input wire logic fault_alarm
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rst_b);
  // ==========================================================
  // helper counters
  int quiet;
  logic [1:0] held;
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      quiet <= 0;
      held <= 2'h0;
    end else begin
      quiet <= rx_byte_valid ? 0 : quiet + 1;
      // settings settle one edge after release, so wait two
      held <= held[1] ? held : held + 2'h1;
    end
  end
  sequence s_reply;
    ##1 (!tx_start && rts);
  endsequence
  // ==========================================================
  // properties
  stop_onehot_a: assert property (comm_fault |-> $onehot({stop_ramp, stop_fast, stop_coast, fault_alarm}))
    else $error("stop outputs not one-hot in fault");
  stop_idle_a: assert property (!comm_fault |-> !(stop_ramp || stop_fast || stop_coast || fault_alarm))
    else $error("stop output without fault");
  silent_addr_a: assert property (addr_match |-> rx_request_address != 8'h00)
    else $error("address zero matched");
  reply_start_a: assert property (tx_start |-> s_reply)
    else $error("reply start not followed by send");
  fault_clear_a: assert property (rx_byte_valid |=> !comm_fault)
    else $error("fault stands after byte");
  fault_silence_a: assert property ($rose(comm_fault) |-> quiet >= TICK_CYCLES)
    else $error("fault raised too early");
  settings_hold_a: assert property (held[1] |-> $stable({bit_period_cycles, parity_enable, parity_odd}))
    else $error("link settings changed after capture");
  parity_legal_a: assert property (parity_odd |-> parity_enable)
    else $error("odd parity without parity");
endmodule : mbcfg_props

bind mbcfg_top mbcfg_props #(.TICK_CYCLES(TICK_CYCLES)) u_props (.sys_clk(sys_clk), .rst_b(rst_b),
  .rx_byte_valid(rx_byte_valid), .rx_request_address(rx_request_address), .addr_match(addr_match),
  .tx_start(tx_start), .rts(rts), .bit_period_cycles(bit_period_cycles), .parity_enable(parity_enable),
  .parity_odd(parity_odd), .comm_fault(comm_fault), .stop_ramp(stop_ramp), .stop_fast(stop_fast),
  .stop_coast(stop_coast), .fault_alarm(fault_alarm));

// [testbench/mbcfg_master_model.sv]
`timescale 1ns/1ps
module mbcfg_master_model
  import mbcfg_pkg::*;
(
  // clock and reset
  input wire logic sys_clk,
  input wire logic rst_b,
  // bench commands
  input wire logic send_req,
  input wire logic [7:0] req_addr,
  input wire logic slow,
  // link side
  input wire logic tx_start,
  output logic rx_byte_valid,
  output logic rx_request_done,
  output logic [7:0] rx_request_address,
  output logic tx_done
);
  logic [7:0] last_addr;
  logic [2:0] cnt;
  logic busy;
  // each bench request is one byte that also ends the request in that cycle
  assign rx_byte_valid = send_req;
  assign rx_request_done = send_req;
  // between frames the address lines show the inverse of the last byte
  assign rx_request_address = send_req ? req_addr : ~last_addr;
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      last_addr <= 8'h00;
      cnt <= 3'h0;
      busy <= 1'b0;
      tx_done <= 1'b0;
    end else begin
      tx_done <= 1'b0;
      if (send_req) last_addr <= req_addr;
      if (tx_start) begin
        busy <= 1'b1;
        cnt <= slow ? 3'h5 : 3'h0;
      end else if (busy) begin
        if (cnt == 3'h0) begin
          tx_done <= 1'b1;
          busy <= 1'b0;
        end else cnt <= cnt - 3'h1;
      end
    end
  end
endmodule : mbcfg_master_model

// [testbench/tb_top.sv]
`timescale 1ns/1ps
module tb_top
  import mbcfg_pkg::*;
;
  logic sys_clk = 0, rst_b = 0, reg_wr = 0, reg_rd = 0, send_req = 0, slow = 0;
  logic [7:0] reg_addr = 0, sa = 0, req_addr = 0, rxa;
  logic [31:0] reg_wdata = 0, reg_rdata;
  logic [3:0] bc = 0;
  logic [1:0] ps = 0;
  logic [15:0] vraw = 16'h04D2, vreg;
  logic rxv, rxd, txd, am, txs, rts, pe, po, cf, sr, sf, sc, fa, irq;
  logic [19:0] bpc;
  int error_cnt = 0, checked = 0, k;
  int bauds[10] = '{1200, 2400, 4800, 9600, 19200, 38400, 57600, 76800, 115200, 9600};
  logic [1:0] pexp[4] = '{2'h0, 2'h2, 2'h3, 2'h0};
  logic [39:0] rows[7] = '{{REG_CTRL, 32'h0F}, {REG_TIMEOUT, 32'h14}, {REG_WAIT, 32'h05}, {REG_IRQ_MASK, 32'h00},
    {REG_IRQ_STATUS, 32'h00}, {8'h1C, 32'h00}, {REG_ACTIVE, 32'h282A}};
  initial forever #4 sys_clk = ~sys_clk;
  mbcfg_top #(.TICK_CYCLES(8), .MS_CYCLES(4)) dut (.sys_clk(sys_clk), .rst_b(rst_b), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .station_address_setting(sa),
    .baud_code_setting(bc), .parity_select_setting(ps), .rx_byte_valid(rxv), .rx_request_done(rxd),
    .rx_request_address(rxa), .tx_done(txd), .addr_match(am), .tx_start(txs), .rts(rts), .bit_period_cycles(bpc),
    .parity_enable(pe), .parity_odd(po), .comm_fault(cf), .stop_ramp(sr), .stop_fast(sf), .stop_coast(sc),
    .fault_alarm(fa), .irq(irq), .volt_monitor_raw(vraw), .volt_monitor_reg(vreg));
  mbcfg_master_model u_master (.sys_clk(sys_clk), .rst_b(rst_b), .send_req(send_req), .req_addr(req_addr),
    .slow(slow), .tx_start(txs), .rx_byte_valid(rxv), .rx_request_done(rxd), .rx_request_address(rxa), .tx_done(txd));
  // ==========================================================
  // tasks
  task chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      error_cnt++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge sys_clk) {reg_wr, reg_addr, reg_wdata} <= {1'b1, a, d};
    @(posedge sys_clk) reg_wr <= 1'b0;
  endtask : wr
  task rd(input logic [7:0] a, input logic [31:0] e);
    @(posedge sys_clk) {reg_rd, reg_addr} <= {1'b1, a};
    @(posedge sys_clk) reg_rd <= 1'b0;
    #1 chk(reg_rdata, e);
  endtask : rd
  task do_reset();
    rst_b <= 1'b0;
    repeat (20) @(posedge sys_clk);
    rst_b <= 1'b1;
    repeat (2) @(posedge sys_clk);
  endtask : do_reset
  task poke(input logic [7:0] a);
    @(posedge sys_clk) {send_req, req_addr} <= {1'b1, a};
    @(posedge sys_clk) send_req <= 1'b0;
  endtask : poke
  // one more than the edges until the chosen flag shows, 200 if it never does
  task wait_on(input int w);
    k = 1;
    #1 while ((w ? txs : cf) !== 1'b1 && k < 200) begin
      @(posedge sys_clk);
      #1 k++;
    end
  endtask : wait_on
  task complete_run();
    $display("errors %0d, comparisons %0d", error_cnt, checked);
    if (error_cnt == 0 && checked > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : complete_run
  initial begin
    #200000;
    error_cnt++;
    complete_run();
  end
  // ==========================================================
  // sequence
  initial begin
    for (int i = 0; i < 10; i++) begin
      {bc, ps} <= {4'(i), 2'(i)};
      do_reset();
      #1 chk(32'(bpc), CLK_HZ / bauds[i]);
      chk({pe, po}, pexp[i % 4]);
    end
    {sa, bc, ps} <= {8'h2A, 4'h8, 2'h2};
    do_reset();
    {sa, bc, ps} <= {8'h55, 4'h1, 2'h1};
    for (int i = 0; i < 7; i++) rd(rows[i][39:32], rows[i][31:0]);
    chk({pe, po, bpc}, {2'h3, 20'(CLK_HZ / 115200)});
    wr(REG_TIMEOUT, 32'h7F);
    rd(REG_TIMEOUT, 32'h64);
    wr(REG_TIMEOUT, 32'h00);
    for (int s = 0; s < 4; s++) begin
      wr(REG_CTRL, 32'h0C | s);
      poke(8'h01);
      wait_on(0);
      chk(k, 10);
      chk({sr, sf, sc, fa}, 4'h8 >> s);
      poke(8'h01);
      #1 chk(cf, 1'b0);
    end
    rd(REG_IRQ_STATUS, 32'h01);
    wr(REG_CTRL, 32'h0B);
    wr(REG_IRQ_STATUS, 32'h03);
    poke(8'h01);
    repeat (30) @(posedge sys_clk);
    #1 chk(cf, 1'b0);
    slow <= 1'b1;
    poke(8'h2B);
    wait_on(1);
    chk(k, 200);
    @(posedge sys_clk) {send_req, req_addr} <= {1'b1, 8'h2A};
    #1 chk(am, 1'b1);
    @(posedge sys_clk) send_req <= 1'b0;
    wait_on(1);
    chk(k, 1 + 5 * 4);
    @(posedge sys_clk) #1 chk(rts, 1'b1);
    repeat (10) @(posedge sys_clk);
    #1 chk(rts, 1'b0);
    rd(REG_IRQ_STATUS, 32'h02);
    wr(REG_IRQ_STATUS, 32'h02);
    slow <= 1'b0;
    wr(REG_WAIT, 32'h02);
    poke(8'h2A);
    wait_on(1);
    chk(k, 1 + 2 * 4);
    repeat (6) @(posedge sys_clk);
    rd(REG_IRQ_STATUS, 32'h02);
    wr(REG_IRQ_MASK, 32'h02);
    #1 chk(irq, 1'b1);
    wr(REG_IRQ_STATUS, 32'h02);
    #1 chk(irq, 1'b0);
    wr(REG_CTRL, 32'h03);
    #1 chk(rts, 1'b1);
    wr(REG_CTRL, 32'h13);
    repeat (2) @(posedge sys_clk);
    #1 chk(vreg, 16'h007B);
    rd(REG_VOLT, 32'h7B);
    wr(REG_CTRL, 32'h03);
    repeat (2) @(posedge sys_clk);
    #1 chk(vreg, vraw);
    sa <= 8'h00;
    do_reset();
    @(posedge sys_clk) {send_req, req_addr} <= {1'b1, 8'h00};
    #1 chk(am, 1'b0);
    @(posedge sys_clk) send_req <= 1'b0;
    wait_on(1);
    chk(k, 200);
    complete_run();
  end
endmodule : tb_top
